//--- design/dsc_instruction_timing_decode.sv
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ns
module dsc_instruction_timing_decode
	import dsc_decode_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// program memory words
	input wire logic [23:0] word_data,
	input wire logic word_valid,
	output logic word_ready,
	// result flags from execution
	input wire logic flag_upd,
	input wire logic [4:0] flag_res,
	input wire logic dsp_upd,
	input wire logic [3:0] dsp_res,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// issue
	output logic exec_valid,
	output logic exec_nop,
	output logic exec_double,
	output logic [7:0] exec_opcode,
	// decoded operands
	output logic [1:0] size_mode,
	output logic shadow_sel,
	output logic acc_sel,
	output logic [1:0] awb_mode,
	output logic [3:0] awb_reg,
	output logic [3:0] bit_position_field,
	output logic [12:0] file_addr,
	output logic dest_is_default_work_register,
	output logic [22:0] program_address_literal,
	output logic prog_addr_ok,
	output logic [15:0] signed_ten_literal,
	output logic [15:0] signed_sixteen_literal,
	output logic [3:0] base_work_register,
	output logic [2:0] dest_mode,
	output logic [3:0] square_reg,
	// status flags
	output logic [4:0] mcu_flags,
	output logic [3:0] dsp_flags
);

	// ==========================================
	// state
	typedef struct packed {
		phase_t st;
		logic [23:0] w1;
		logic [1:0] extra;
		logic [2:0] cyc;
		logic skipped;
		logic skip_dw;
		logic ready;
		logic run;
		logic done;
		logic xv;
		logic xn;
		logic xd;
		logic [7:0] opcode;
		logic [1:0] size;
		logic shadow;
		logic acc;
		logic [1:0] accumulator_writeback_target;
		logic [3:0] bitpos;
		logic [12:0] faddr;
		logic dwreg;
		logic [22:0] paddr;
		logic pok;
		logic [15:0] s10;
		logic [15:0] s16;
		logic [3:0] base;
		logic [2:0] dmode;
		logic [3:0] sq;
		logic [4:0] mcu;
		logic [3:0] dsp;
		logic [2:0] err;
		logic [2:0] last_cyc;
		logic [15:0] icount;
		logic [15:0] rdata;
	} core_t;

	core_t q;
	core_t n;

	// ==========================================
	// helpers
	function automatic logic is_double(input logic [7:0] op);
		is_double = (op == OPC_CALL_DW) || (op == OPC_GOTO_DW) || (op == OPC_LOOP_DW);
	endfunction : is_double

	// no-op cycles that follow the issue cycle
	function automatic logic [1:0] extra_of(input logic [7:0] op, input logic taken);
		unique case (op)
			OPC_BRANCH, OPC_IND_JUMP, OPC_TBL_RD, OPC_TBL_WR: extra_of = EXTRA_ONE;
			OPC_RETURN, OPC_INT_RETURN: extra_of = EXTRA_TWO;
			OPC_MOV_DW: extra_of = EXTRA_ONE;
			OPC_CBRANCH: extra_of = taken ? EXTRA_ONE : 2'h0;
			default: extra_of = 2'h0;
		endcase
	endfunction : extra_of

	// testable flags; index 15 means always
	function automatic logic [15:0] cond_vec(input core_t c);
		cond_vec = {1'b1, 6'h00, c.dsp, c.mcu};
	endfunction : cond_vec

	// operand fields of one word; overlapping views, datapath picks per class
	function automatic core_t fill_fields(input core_t c, input logic [23:0] w);
		core_t r;
		r = c;
		r.opcode = w[OPC_LSB +: 8];
		unique case (w[SIZE_LSB +: 2])
			SZ_BYTE: r.size = SZ_BYTE;
			SZ_DOUBLE: r.size = SZ_DOUBLE;
			default: r.size = SZ_WORD;
		endcase
		r.shadow = w[SHADOW_BIT];
		r.acc = w[ACC_BIT];
		unique case (w[AWB_LSB +: 2])
			2'h0: r.accumulator_writeback_target = AWB_DIRECT;
			2'h1: r.accumulator_writeback_target = AWB_POSTINC;
			default: r.accumulator_writeback_target = AWB_NONE;
		endcase
		r.bitpos = w[BITPOS_LSB +: 4];
		r.faddr = w[0 +: FADDR_W];
		r.dwreg = !w[DEST_SEL_BIT];
		r.s10 = {{6{w[S10_LSB + 9]}}, w[S10_LSB +: 10]};
		r.s16 = w[S16_LSB +: 16];
		r.base = w[BASE_LSB +: 4];
		r.dmode = w[DMODE_LSB +: 3];
		r.sq = SQ_BASE + {2'b00, w[SQ_LSB +: 2]};
		fill_fields = r;
	endfunction : fill_fields

	// ==========================================
	// next state
	always_comb
	begin
		logic take;
		logic taken;
		logic [7:0] op;
		logic [15:0] cv;
		take = 1'b0;
		taken = 1'b0;
		op = 8'h00;
		cv = 16'h0000;
		n = q;
		n.xv = 1'b0;
		n.xn = 1'b0;
		n.xd = 1'b0;
		n.done = 1'b0;
		n.rdata = 16'h0000;
		take = word_valid && q.ready;
		op = word_data[OPC_LSB +: 8];
		// flag vector held in a variable so one bit can be picked from it
		cv = cond_vec(q);
		unique case (q.st)
			S_RUN:
			begin
				if (take)
				begin
					if (is_double(op))
					begin
						// hold first half until its partner arrives
						n.w1 = word_data;
						n.cyc = 3'h1;
						n.st = S_SECOND;
					end
					else
					begin
						n = fill_fields(n, word_data);
						n.xv = 1'b1;
						n.cyc = 3'h1;
						n.skipped = 1'b0;
						n.skip_dw = 1'b0;
						if (n.dmode == DM_BAD)
						begin
							n.err[2] = 1'b1;
						end
						if (op == OPC_SKIP)
						begin
							taken = cv[word_data[BITPOS_LSB +: 4]];
						end
						else
						begin
							taken = cv[word_data[COND_LSB +: 4]];
						end
						if (op == OPC_SKIP && taken)
						begin
							n.skipped = 1'b1;
							n.st = S_SKIP;
						end
						else if (extra_of(op, taken) != 2'h0)
						begin
							n.extra = extra_of(op, taken);
							n.st = S_EXTRA;
						end
						else
						begin
							// opcode zero, lone second word included, ends here
							n.done = 1'b1;
							n.last_cyc = 3'h1;
						end
					end
				end
			end
			S_SECOND:
			begin
				if (take)
				begin
					n = fill_fields(n, q.w1);
					n.paddr = {word_data[PHI_LSB +: 7], q.w1[15:0]};
					n.pok = !q.w1[0];
					if (q.w1[0])
					begin
						n.err[0] = 1'b1;
					end
					if (word_data[OPC_LSB +: 8] != OPC_NOP)
					begin
						n.err[1] = 1'b1;
					end
					n.xv = 1'b1;
					n.xd = 1'b1;
					n.skipped = 1'b0;
					n.done = 1'b1;
					n.last_cyc = DW_CYCLES;
					n.st = S_RUN;
				end
			end
			S_EXTRA:
			begin
				// filler cycle, no word is taken
				n.xn = 1'b1;
				n.cyc = q.cyc + 3'h1;
				n.extra = q.extra - 2'h1;
				if (q.extra == EXTRA_ONE)
				begin
					n.done = 1'b1;
					n.last_cyc = q.cyc + 3'h1;
					n.st = S_RUN;
				end
			end
			S_SKIP:
			begin
				if (take)
				begin
					n.xn = 1'b1;
					n.cyc = q.cyc + 3'h1;
					if (is_double(op))
					begin
						n.skip_dw = 1'b1;
						n.st = S_SKIP2;
					end
					else
					begin
						n.done = 1'b1;
						n.last_cyc = q.cyc + 3'h1;
						n.st = S_RUN;
					end
				end
			end
			S_SKIP2:
			begin
				if (take)
				begin
					n.xn = 1'b1;
					n.cyc = q.cyc + 3'h1;
					n.done = 1'b1;
					n.last_cyc = q.cyc + 3'h1;
					n.st = S_RUN;
				end
			end
			default: n.st = S_RUN;
		endcase
		if (n.done)
		begin
			n.icount = q.icount + 16'h0001;
		end
		// software writes before flag updates so a same-cycle flag update wins; a count write beats the increment
		if (reg_wr)
		begin
			unique case (reg_addr)
				REG_CTRL: n.run = reg_wdata[0];
				REG_MCU: n.mcu = reg_wdata[4:0];
				REG_DSP: n.dsp = reg_wdata[3:0];
				REG_DEC: n.err = n.err & ~(reg_wdata[2:0] & ~(n.err ^ q.err));
				REG_CNT: n.icount = reg_wdata;
				default: n.run = n.run;
			endcase
		end
		// result flags; zero only ever cleared by a nonzero result
		if (flag_upd)
		begin
			n.mcu[3:0] = flag_res[3:0];
			n.mcu[4] = n.mcu[4] & flag_res[4];
		end
		if (dsp_upd)
		begin
			n.dsp = dsp_res;
		end
		if (reg_rd)
		begin
			unique case (reg_addr)
				REG_CTRL: n.rdata = {15'h0000, q.run};
				REG_MCU: n.rdata = {11'h000, q.mcu};
				REG_DSP: n.rdata = {12'h000, q.dsp};
				REG_DEC: n.rdata = {q.opcode, 1'b0, q.last_cyc, 1'b0, q.err};
				REG_CNT: n.rdata = q.icount;
				default: n.rdata = 16'h0000;
			endcase
		end
		n.ready = n.run && (n.st != S_EXTRA);
	end

	// ==========================================
	// state register
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			q <= '0;
			q.st <= S_RUN;
			q.run <= RUN_RST;
			q.ready <= RUN_RST;
			q.mcu <= MCU_RST;
			q.dsp <= DSP_RST;
			q.size <= SZ_WORD;
			q.accumulator_writeback_target <= AWB_NONE;
		end
		else
		begin
			q <= n;
		end
	end

	// ==========================================
	// outputs
	assign word_ready = q.ready;
	assign reg_rdata = q.rdata;
	assign exec_valid = q.xv;
	assign exec_nop = q.xn;
	assign exec_double = q.xd;
	assign exec_opcode = q.opcode;
	assign size_mode = q.size;
	assign shadow_sel = q.shadow;
	assign acc_sel = q.acc;
	assign awb_mode = q.accumulator_writeback_target;
	assign awb_reg = AWB_REG;
	assign bit_position_field = q.bitpos;
	assign file_addr = q.faddr;
	assign dest_is_default_work_register = q.dwreg;
	assign program_address_literal = q.paddr;
	assign prog_addr_ok = q.pok;
	assign signed_ten_literal = q.s10;
	assign signed_sixteen_literal = q.s16;
	assign base_work_register = q.base;
	assign dest_mode = q.dmode;
	assign square_reg = q.sq;
	assign mcu_flags = q.mcu;
	assign dsp_flags = q.dsp;

	// ==========================================
	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_one_nop;
		exec_nop ##1 !exec_nop;
	endsequence
	sequence s_two_nop;
		exec_nop [*2] ##1 !exec_nop;
	endsequence

	a_branch_one_nop: assert property (
		exec_valid && exec_opcode == OPC_BRANCH |=> s_one_nop)
		else $error("branch did not take two cycles");
	a_return_two_nop: assert property (
		exec_valid && (exec_opcode == OPC_RETURN || exec_opcode == OPC_INT_RETURN)
		|=> s_two_nop)
		else $error("return did not take three cycles");
	a_nop_single: assert property (
		exec_valid && exec_opcode == OPC_NOP && !exec_double |=> !exec_nop)
		else $error("no-op word took extra cycles");
	a_double_two_cyc: assert property (
		exec_valid && exec_double |-> q.done && q.last_cyc == DW_CYCLES)
		else $error("double-word instruction length wrong");
	a_skip_length: assert property (
		q.done && q.skipped |-> q.last_cyc == (q.skip_dw ? SKIP_DW_CYCLES : SKIP_SW_CYCLES))
		else $error("skip length wrong");
	a_prog_addr_lsb: assert property (
		exec_valid && exec_double |-> prog_addr_ok == !program_address_literal[0]
		&& (prog_addr_ok || q.err[0]))
		else $error("program address literal check wrong");
	a_slit_sign: assert property (
		exec_valid |-> signed_ten_literal[15:9] == {7{signed_ten_literal[9]}})
		else $error("ten-bit literal not sign extended");
	a_square_range: assert property (
		exec_valid |-> square_reg >= 4'h4 && square_reg <= 4'h7)
		else $error("square register out of range");
	a_sticky_zero: assert property (
		flag_upd && !flag_res[4] |=> !mcu_flags[4])
		else $error("zero flag survived nonzero result");

endmodule : dsc_instruction_timing_decode

//--- include/dsc_decode_pkg.sv
// Behaviour
// - two program words joined form one 48-bit instruction with all operands
// - second word has upper eight bits zero; fetched alone it runs as no-op
// - plain instruction takes one cycle; taken test or PC change adds no-op cycle
// - branches other than untaken conditional ones, indirect jumps, table ops and returns take two or three cycles
// - taken skip costs two cycles, three when skipped instruction is double-word
// - double-word data moves take two cycles
// - every two-word instruction executes in exactly two cycles
// - byte, word, double-word sizes, word by default; shadow register option
// - dsp instructions select accumulator A or B
// - accumulator write-back goes to W13 or to [W13] with post-increment two
// - bit position field is four bits, positions 0 to 15
// - file register address covers 0 to 0x1FFF
// - 23-bit program address literal must have bit zero clear
// - signed literals sign-extended: ten-bit and sixteen-bit ranges
// - base register field selects any of sixteen working registers
// - dsp destination: direct, indirect, post/pre-modified, base offset forms
// - square operands only W4 to W7 each times itself
// - carry, digit carry, negative, overflow and sticky zero flags kept
// - overflow and saturation flags kept per accumulator
// - single word is 24 bits with an 8-bit opcode field
// - file register result goes to file register or default W0
package dsc_decode_pkg;
	// ==========================================
	// widths
	localparam int WORD_W = 24;
	localparam int DATA_W = 16;
	localparam int OPC_LSB = 16;
	// ==========================================
	// opcode classes
	localparam logic [7:0] OPC_NOP = 8'h00;
	localparam logic [7:0] OPC_IND_JUMP = 8'h01;
	localparam logic [7:0] OPC_CALL_DW = 8'h02;
	localparam logic [7:0] OPC_GOTO_DW = 8'h04;
	localparam logic [7:0] OPC_RETURN = 8'h06;
	localparam logic [7:0] OPC_INT_RETURN = 8'h07;
	localparam logic [7:0] OPC_LOOP_DW = 8'h08;
	localparam logic [7:0] OPC_CBRANCH = 8'h30;
	localparam logic [7:0] OPC_BRANCH = 8'h37;
	localparam logic [7:0] OPC_SKIP = 8'haf;
	localparam logic [7:0] OPC_TBL_RD = 8'hba;
	localparam logic [7:0] OPC_TBL_WR = 8'hbb;
	localparam logic [7:0] OPC_MOV_DW = 8'hbe;
	// ==========================================
	// field positions inside a word
	localparam int ACC_BIT = 15;
	localparam int SIZE_LSB = 14;
	localparam int SHADOW_BIT = 13;
	localparam int DEST_SEL_BIT = 13;
	localparam int BITPOS_LSB = 12;
	localparam int BASE_LSB = 7;
	localparam int DMODE_LSB = 4;
	localparam int S10_LSB = 4;
	localparam int S16_LSB = 4;
	localparam int COND_LSB = 0;
	localparam int AWB_LSB = 0;
	localparam int SQ_LSB = 0;
	localparam int PHI_LSB = 0;
	localparam int FADDR_W = 13;
	// ==========================================
	// field codes
	localparam logic [1:0] SZ_WORD = 2'h0;
	localparam logic [1:0] SZ_BYTE = 2'h1;
	localparam logic [1:0] SZ_DOUBLE = 2'h2;
	localparam logic [1:0] AWB_DIRECT = 2'h0;
	localparam logic [1:0] AWB_POSTINC = 2'h1;
	localparam logic [1:0] AWB_NONE = 2'h2;
	localparam logic [3:0] AWB_REG = 4'hd;
	localparam logic [2:0] AWB_INC = 3'h2;
	localparam logic [3:0] SQ_BASE = 4'h4;
	localparam logic [3:0] DEFAULT_WORK_REGISTER_IDX = 4'h0;
	localparam logic [2:0] DM_BAD = 3'h7;
	// ==========================================
	// cycle counts
	localparam logic [1:0] EXTRA_ONE = 2'h1;
	localparam logic [1:0] EXTRA_TWO = 2'h2;
	localparam logic [2:0] DW_CYCLES = 3'h2;
	localparam logic [2:0] SKIP_SW_CYCLES = 3'h2;
	localparam logic [2:0] SKIP_DW_CYCLES = 3'h3;
	// ==========================================
	// register map and reset values
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_MCU = 3'h1;
	localparam logic [2:0] REG_DSP = 3'h2;
	localparam logic [2:0] REG_DEC = 3'h3;
	localparam logic [2:0] REG_CNT = 3'h4;
	localparam logic RUN_RST = 1'b1;
	localparam logic [4:0] MCU_RST = 5'h00;
	localparam logic [3:0] DSP_RST = 4'h0;
	typedef enum logic [2:0] {
		S_RUN = 3'h0,
		S_SECOND = 3'h1,
		S_EXTRA = 3'h2,
		S_SKIP = 3'h3,
		S_SKIP2 = 3'h4
	} phase_t;
endpackage : dsc_decode_pkg

//--- sim/prog_mem_model.sv
`timescale 1ns/1ns
module prog_mem_model
	import dsc_decode_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// bench control
	input wire logic start,
	input wire logic slow,
	input wire logic [3:0] prog_len,
	output logic done,
	// word stream
	input wire logic word_ready,
	output logic [23:0] word_data,
	output logic word_valid
);
	// ====
	// program store
	logic [23:0] mem [0:7] = '{default: 24'h0000_00};
	logic [3:0] pc;
	logic [3:0] len_ff;
	logic gap;
	// word held until taken; idle data is inverted so stale words never look fresh
	assign word_valid = (pc < len_ff) && !gap;
	assign word_data = word_valid ? mem[pc[2:0]] : ~mem[pc[2:0] - 3'h1];
	assign done = (pc >= len_ff);
	// fetch pointer; slow mode idles one cycle after each take
	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pc <= 4'h0;
			len_ff <= 4'h0;
			gap <= 1'b0;
		end
		else if (start)
		begin
			pc <= 4'h0;
			len_ff <= prog_len;
			gap <= 1'b0;
		end
		else if (word_valid && word_ready)
		begin
			pc <= pc + 4'h1;
			gap <= slow;
		end
		else
			gap <= 1'b0;
	end
endmodule : prog_mem_model

//--- sim/tb.sv
`timescale 1ns/1ns
module tb
	import dsc_decode_pkg::*;
;
	// ====
	// bench signals
	logic ref_clk, rstn, word_valid, word_ready, flag_upd, dsp_upd, reg_wr, reg_rd, start, slow;
	logic exec_valid, exec_nop, exec_double, shadow_sel, acc_sel, prog_addr_ok, pm_done;
	logic dest_is_default_work_register;
	logic [23:0] word_data;
	logic [22:0] program_address_literal;
	logic [15:0] reg_wdata, reg_rdata, signed_ten_literal, signed_sixteen_literal;
	logic [12:0] file_addr;
	logic [7:0] exec_opcode;
	logic [4:0] flag_res, mcu_flags;
	logic [3:0] dsp_res, awb_reg, bit_position_field, base_work_register, square_reg;
	logic [3:0] dsp_flags, prog_len;
	logic [2:0] reg_addr, dest_mode;
	logic [1:0] size_mode, awb_mode;
	int bad_count, comparisons, cyc, n_busy, n_dbl;

	dsc_instruction_timing_decode dsc_instruction_timing_decode_inst (
		.ref_clk, .rstn, .word_data, .word_valid, .word_ready, .flag_upd, .flag_res, .dsp_upd,
		.dsp_res, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .exec_valid, .exec_nop,
		.exec_double, .exec_opcode, .size_mode, .shadow_sel, .acc_sel, .awb_mode, .awb_reg,
		.bit_position_field, .file_addr, .dest_is_default_work_register,
		.program_address_literal, .prog_addr_ok, .signed_ten_literal, .signed_sixteen_literal,
		.base_work_register, .dest_mode, .square_reg, .mcu_flags, .dsp_flags
	);
	prog_mem_model prog_mem_model_inst (
		.ref_clk, .rstn, .start, .slow, .prog_len, .done(pm_done), .word_ready, .word_data,
		.word_valid
	);

	// ====
	// clock
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// busy slots and hang guard; slots count issue plus filler cycles
	always @(posedge ref_clk)
	begin
		n_busy += int'(exec_valid === 1'b1) + int'(exec_nop === 1'b1);
		n_dbl += int'(exec_valid === 1'b1 && exec_double === 1'b1);
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			$display("ERROR %0t timeout", $time);
			tally_and_finish();
		end
	end

	// ====
	// tasks
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	// read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [2:0] a, input logic [15:0] exp, input string what);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp, what);
	endtask : reg_read
	task automatic upd(input logic [4:0] f, input logic [3:0] d);
		@(posedge ref_clk);
		flag_upd <= 1'b1;
		flag_res <= f;
		dsp_upd <= 1'b1;
		dsp_res <= d;
		@(posedge ref_clk);
		flag_upd <= 1'b0;
		dsp_upd <= 1'b0;
		#1;
	endtask : upd
	task automatic run_prog(input logic [23:0] w [$], input logic sl, input logic hold,
		input int exp_busy, input int exp_dbl, input string nm);
		int i;
		foreach (w[k]) prog_mem_model_inst.mem[k] = w[k];
		@(posedge ref_clk);
		prog_len <= 4'(w.size());
		slow <= sl;
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		#1 n_busy = 0;
		n_dbl = 0;
		if (hold)
		begin
			repeat (4) @(posedge ref_clk);
			chk(n_busy, 0, "halted issue");
			chk(word_ready, 1'b0, "halted ready");
			reg_write(REG_CTRL, 16'h0001);
		end
		for (i = 0; i < 60 && !pm_done; i++) @(posedge ref_clk);
		repeat (6) @(posedge ref_clk);
		chk(n_busy, exp_busy, {nm, " slots"});
		chk(n_dbl, exp_dbl, {nm, " doubles"});
		$display("test %s done", nm);
	endtask : run_prog
	// operand views of the last issued word
	task automatic chk_fields(input logic [23:0] w);
		chk(exec_opcode, w[23:16], "opcode");
		chk(acc_sel, w[ACC_BIT], "acc");
		chk(bit_position_field, w[BITPOS_LSB+:4], "bitpos");
		chk(base_work_register, w[BASE_LSB+:4], "base");
		chk(file_addr, w[12:0], "faddr");
		chk(signed_ten_literal, {{6{w[S10_LSB+9]}}, w[S10_LSB+:10]}, "s10");
		chk(square_reg, SQ_BASE + w[SQ_LSB+:2], "square");
		chk(awb_reg, AWB_REG, "awb");
		chk(awb_mode, (w[AWB_LSB+:2] > 2'h1) ? AWB_NONE : w[AWB_LSB+:2], "awbm");
		chk(shadow_sel, w[SHADOW_BIT], "shadow");
		chk(dest_is_default_work_register, !w[DEST_SEL_BIT], "default_work_register");
		chk(signed_sixteen_literal, w[S16_LSB+:16], "s16");
		chk(dest_mode, w[DMODE_LSB+:3], "dmode");
		chk(size_mode, (w[SIZE_LSB+:2] == 2'h3) ? SZ_WORD : w[SIZE_LSB+:2], "size");
	endtask : chk_fields
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	// ====
	// main sequence
	initial
	begin
		{rstn, flag_upd, dsp_upd, reg_wr, reg_rd, start, slow} = '0;
		{flag_res, dsp_res, reg_addr, reg_wdata, prog_len} = '0;
		{bad_count, comparisons, cyc, n_busy, n_dbl} = '0;
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		// reset values and an unmapped slot
		reg_read(REG_CTRL, 16'h0001, "ctrl");
		reg_read(REG_MCU, 16'h0000, "mcu");
		reg_read(REG_DSP, 16'h0000, "dsp");
		reg_write(3'h7, 16'hffff);
		reg_read(3'h7, 16'h0000, "unmapped");
		$display("test regs done");
		run_prog('{24'h40_b5a6}, 0, 0, 1, 0, "plain");
		chk_fields(24'h40_b5a6);
		run_prog('{24'h40_c20b}, 0, 0, 1, 0, "size3");
		chk_fields(24'h40_c20b);
		run_prog('{24'h37_0000, 24'h40_0000}, 0, 0, 3, 0, "branch");
		run_prog('{24'h06_0000, 24'h07_0000}, 0, 0, 6, 0, "returns");
		run_prog('{24'hba_0000, 24'hbb_0000}, 0, 0, 4, 0, "tables");
		run_prog('{24'hbe_0000}, 0, 0, 2, 0, "dw move");
		chk_fields(24'hbe_0000);
		run_prog('{24'h02_1234, 24'h00_0045}, 0, 0, 1, 1, "call");
		chk(program_address_literal, 23'h45_1234, "addr");
		chk(prog_addr_ok, 1'b1, "even");
		chk_fields(24'h02_1234);
		run_prog('{24'h08_0000, 24'h00_0000, 24'h04_1235, 24'h00_0001}, 0, 0, 2, 2, "goto");
		chk(program_address_literal, 23'h01_1235, "addr2");
		chk(prog_addr_ok, 1'b0, "odd");
		// odd address leaves a sticky error; write one clears it
		reg_read(REG_DEC, {OPC_GOTO_DW, 1'b0, DW_CYCLES, 4'h1}, "dec err");
		reg_write(REG_DEC, 16'h0001);
		reg_read(REG_DEC, {OPC_GOTO_DW, 1'b0, DW_CYCLES, 4'h0}, "dec clr");
		$display("test dec done");
		run_prog('{24'h00_0045}, 0, 0, 1, 0, "lone");
		chk_fields(24'h00_0045);
		run_prog('{24'haf_f000, 24'h40_0000, 24'h40_0000}, 0, 0, 3, 0, "skip sw");
		run_prog('{24'haf_f000, 24'h02_1234, 24'h00_0045, 24'h40_0000}, 0, 0, 4, 0, "skip dw");
		run_prog('{24'h30_0000, 24'h30_000f, 24'h40_0000}, 0, 0, 4, 0, "cond");
		run_prog('{24'h37_0000, 24'h40_0000}, 1, 0, 3, 0, "slow");
		reg_write(REG_CTRL, 16'h0000);
		run_prog('{24'h40_0000}, 0, 1, 1, 0, "halted");
		// flags: zero flag is sticky across zero results
		upd(5'h0f, 4'ha);
		chk(mcu_flags, 5'h0f, "mcu1");
		chk(dsp_flags, 4'ha, "dsp1");
		reg_write(REG_MCU, 16'h0010);
		upd(5'h10, 4'h5);
		chk(mcu_flags, 5'h10, "mcu2");
		chk(dsp_flags, 4'h5, "dsp2");
		upd(5'h05, 4'h0);
		reg_read(REG_MCU, 16'h0005, "mcu3");
		reg_read(REG_DSP, 16'h0000, "dsp3");
		$display("test flags done");
		tally_and_finish();
	end
endmodule : tb
